// ==== shared/port_stats_defines.vh ====
// Constants for the per-port traffic statistics block.
// Assumes inclusion by bare name from design files.
`ifndef PORT_STATS_DEFINES_VH
`define PORT_STATS_DEFINES_VH
`define MIN_FRAME_LEN      16'h0040
`define MAX_FRAME_LEN      16'h0600
`define LATE_COLL_OCTET    16'h0040
`define HIST_65            16'h0041
`define HIST_128           16'h0080
`define HIST_256           16'h0100
`define HIST_512           16'h0200
`define HIST_1024          16'h0400
`define CLOCK_MHZ          250
`define UTIL_INTERVAL_MS   1000
`define UTIL_INTERVAL_CYC  (`UTIL_INTERVAL_MS * `CLOCK_MHZ * 1000)
`define LINK_BYTES_PER_IV  32'h07735940
`endif

// ==== verilog/event_counter.v ====
// One saturation-free statistics counter.
// Assumes a synchronous increment strobe from the same clock.
`timescale 1ns/100ps
module event_counter #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rstn,
  // Increment
  input  wire             inc,
  input  wire [15:0]      amount,
  // Value
  output reg  [WIDTH-1:0] count
);
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= {WIDTH{1'b0}};
    end else if (inc) begin
      count <= count + {{(WIDTH-16){1'b0}}, amount}; // see R23
    end
  end
endmodule

// ==== verilog/util_meter.v ====
// Bandwidth utilization over a fixed interval, in percent.
// Assumes byte strobes from the same clock; link capacity is a parameter.
`timescale 1ns/100ps
`include "port_stats_defines.vh"
module util_meter #(
  parameter        INTERVAL_CYC = `UTIL_INTERVAL_CYC,
  parameter [31:0] CAP_BYTES    = `LINK_BYTES_PER_IV
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rstn,
  // Byte events
  input  wire        add,
  input  wire [15:0] amount,
  // Result
  output reg  [7:0]  percent
);
  reg [31:0] timer_reg;
  reg [39:0] acc_reg;
  wire [39:0] scaled = acc_reg * 40'h64;
  wire [39:0] quot   = scaled / {8'h00, CAP_BYTES};
  reg  [7:0]  pct;
  always @* begin
    // Clamp: counted bytes may exceed the nominal capacity slightly
    if (scaled >= {8'h00, CAP_BYTES} * 40'h64)
      pct = 8'h64;
    else
      pct = quot[7:0];
  end
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timer_reg <= 32'h0;
      acc_reg   <= 40'h0;
      percent   <= 8'h00;
    end else if (timer_reg == INTERVAL_CYC - 1) begin
      timer_reg <= 32'h0;
      percent   <= pct; // see R3
      acc_reg   <= add ? {24'h0, amount} : 40'h0;
    end else begin
      timer_reg <= timer_reg + 32'h1;
      if (add)
        acc_reg <= acc_reg + {24'h0, amount};
    end
  end
endmodule

// ==== verilog/port_traffic_statistics.v ====
// Per-port frame statistics: byte, frame, cast, histogram and error counters.
// Assumes one-cycle end-of-frame summaries from the port MAC, same clock.
// Notes on behaviour
// R1 - Count good transmitted bytes
// R2 - Count good received bytes, dropped included
// R3 - Report utilization percent per interval
// R4 - Count all received bytes
// R5 - Count all received frames
// R6 - Count good received frames, dropped included
// R7 - Count good transmitted frames
// R8 - Keep last received source address
// R9 - Count receive checksum failures
// R10 - Count good frames above maximum length
// R11 - Count short frames with framing/checksum fault
// R12 - Count long frames with checksum/alignment fault
// R13 - Count collisions at or after octet 64
// R14 - Count MAC receive error frames
// R15 - Count dropped frames since reset
// R16 - Count good-checksum frames below minimum
// R17 - Total errors sums eight error counts
// R18 - Count every collision
// R19 - Bin frames into six length ranges
// R20 - Count unicast per direction
// R21 - Count multicast per direction
// R22 - Count broadcast per direction
// R23 - Reset clears; increment only; reads harmless
`timescale 1ns/100ps
`include "port_stats_defines.vh"
module port_traffic_statistics #(
  parameter WIDTH        = 32,
  parameter INTERVAL_CYC = `UTIL_INTERVAL_CYC
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rstn,
  // Receive frame summary
  input  wire             rx_done,
  input  wire [15:0]      rx_len,
  input  wire             rx_crc_bad,
  input  wire             rx_align_bad,
  input  wire             rx_mac_err,
  input  wire             rx_dropped,
  input  wire [47:0]      rx_dst,
  input  wire [47:0]      rx_src,
  // Transmit frame summary
  input  wire             tx_done,
  input  wire             tx_good,
  input  wire [15:0]      tx_len,
  input  wire [47:0]      tx_dst,
  // Collisions
  input  wire             coll,
  input  wire [15:0]      coll_octet,
  // Counter values
  output reg  [WIDTH-1:0] tx_bytes_good,
  output reg  [WIDTH-1:0] rx_bytes_good,
  output reg  [WIDTH-1:0] rx_bytes_total,
  output reg  [WIDTH-1:0] rx_frames_total,
  output reg  [WIDTH-1:0] rx_frames_good,
  output reg  [WIDTH-1:0] tx_frames_good,
  output reg  [47:0]      last_src,
  output reg  [WIDTH-1:0] crc_errors,
  output reg  [WIDTH-1:0] oversize,
  output reg  [WIDTH-1:0] fragments,
  output reg  [WIDTH-1:0] jabbers,
  output reg  [WIDTH-1:0] late_colls,
  output reg  [WIDTH-1:0] mac_rx_errors,
  output reg  [WIDTH-1:0] dropped,
  output reg  [WIDTH-1:0] undersize,
  output reg  [WIDTH-1:0] total_errors,
  output reg  [WIDTH-1:0] collisions,
  output reg  [WIDTH-1:0] hist_64,
  output reg  [WIDTH-1:0] hist_65_127,
  output reg  [WIDTH-1:0] hist_128_255,
  output reg  [WIDTH-1:0] hist_256_511,
  output reg  [WIDTH-1:0] hist_512_1023,
  output reg  [WIDTH-1:0] hist_1024_1536,
  output reg  [WIDTH-1:0] rx_unicast,
  output reg  [WIDTH-1:0] tx_unicast,
  output reg  [WIDTH-1:0] rx_multicast,
  output reg  [WIDTH-1:0] tx_multicast,
  output reg  [WIDTH-1:0] rx_broadcast,
  output reg  [WIDTH-1:0] tx_broadcast,
  output reg  [7:0]       util_percent
);

  ////////////////////////////////////////////////////////////////////////////
  // Classification helpers

  // 2'b00 unicast, 2'b01 multicast, 2'b10 broadcast
  function [1:0] cast_of;
    input [47:0] dst;
    begin
      if (dst == 48'hFFFFFFFFFFFF)
        cast_of = 2'b10;
      else if (dst[40])
        cast_of = 2'b01;
      else
        cast_of = 2'b00;
    end
  endfunction

  // One-hot histogram bin, zero outside 64..1536
  function [5:0] bin_of;
    input [15:0] len;
    begin
      if (len == `MIN_FRAME_LEN)
        bin_of = 6'h01;
      else if (len >= `HIST_65 && len < `HIST_128)
        bin_of = 6'h02;
      else if (len >= `HIST_128 && len < `HIST_256)
        bin_of = 6'h04;
      else if (len >= `HIST_256 && len < `HIST_512)
        bin_of = 6'h08;
      else if (len >= `HIST_512 && len < `HIST_1024)
        bin_of = 6'h10;
      else if (len >= `HIST_1024 && len <= `MAX_FRAME_LEN)
        bin_of = 6'h20;
      else
        bin_of = 6'h00;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Receive classification

  wire rx_short = rx_len < `MIN_FRAME_LEN;
  wire rx_long  = rx_len > `MAX_FRAME_LEN;
  wire rx_fault = rx_crc_bad | rx_align_bad;
  // Good means intact and legal length; drop does not disqualify it
  wire rx_good  = rx_done & ~rx_fault & ~rx_mac_err & ~rx_short & ~rx_long;
  wire [1:0] rx_cast = cast_of(rx_dst);
  wire [1:0] tx_cast = cast_of(tx_dst);
  wire tx_ok = tx_done & tx_good;
  // Histogram counts frames of 64 to 1536 bytes, valid and invalid, by length
  wire [5:0] rx_bin = rx_done ? bin_of(rx_len) : 6'h00;
  wire [5:0] tx_bin = tx_done ? bin_of(tx_len) : 6'h00;

  wire ev_crc   = rx_done & rx_crc_bad;                      // see R9
  wire ev_over  = rx_done & rx_long & ~rx_fault;             // see R10
  wire ev_frag  = rx_done & rx_short & rx_fault;             // see R11
  wire ev_jab   = rx_done & rx_long & rx_fault;              // see R12
  wire ev_late  = coll & (coll_octet >= `LATE_COLL_OCTET);   // see R13
  wire ev_mac   = rx_done & rx_mac_err;                      // see R14
  wire ev_drop  = rx_done & rx_dropped;                      // see R15
  wire ev_under = rx_done & rx_short & ~rx_crc_bad;          // see R16

  // Up to five of the eight may land in one cycle, so total adds their number
  wire [3:0] err_sum = {3'h0, ev_crc} + {3'h0, ev_over} + {3'h0, ev_frag}
                     + {3'h0, ev_jab} + {3'h0, ev_late} + {3'h0, ev_mac}
                     + {3'h0, ev_drop} + {3'h0, ev_under};   // see R17

  ////////////////////////////////////////////////////////////////////////////
  // Counters; reset clears all, nothing else does (see R23)

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_bytes_good   <= {WIDTH{1'b0}};
      rx_bytes_good   <= {WIDTH{1'b0}};
      rx_bytes_total  <= {WIDTH{1'b0}};
      rx_frames_total <= {WIDTH{1'b0}};
      rx_frames_good  <= {WIDTH{1'b0}};
      tx_frames_good  <= {WIDTH{1'b0}};
      last_src        <= 48'h000000000000;
      crc_errors      <= {WIDTH{1'b0}};
      oversize        <= {WIDTH{1'b0}};
      fragments       <= {WIDTH{1'b0}};
      jabbers         <= {WIDTH{1'b0}};
      late_colls      <= {WIDTH{1'b0}};
      mac_rx_errors   <= {WIDTH{1'b0}};
      dropped         <= {WIDTH{1'b0}};
      undersize       <= {WIDTH{1'b0}};
      total_errors    <= {WIDTH{1'b0}};
      hist_64         <= {WIDTH{1'b0}};
      hist_65_127     <= {WIDTH{1'b0}};
      hist_128_255    <= {WIDTH{1'b0}};
      hist_256_511    <= {WIDTH{1'b0}};
      hist_512_1023   <= {WIDTH{1'b0}};
      hist_1024_1536  <= {WIDTH{1'b0}};
      rx_unicast      <= {WIDTH{1'b0}};
      tx_unicast      <= {WIDTH{1'b0}};
      rx_multicast    <= {WIDTH{1'b0}};
      tx_multicast    <= {WIDTH{1'b0}};
      rx_broadcast    <= {WIDTH{1'b0}};
      tx_broadcast    <= {WIDTH{1'b0}};
    end else begin
      if (tx_ok) begin
        tx_bytes_good  <= tx_bytes_good + {{(WIDTH-16){1'b0}}, tx_len}; // see R1
        tx_frames_good <= tx_frames_good + 1'b1;                        // see R7
      end
      if (rx_good) begin
        rx_bytes_good  <= rx_bytes_good + {{(WIDTH-16){1'b0}}, rx_len}; // see R2
        rx_frames_good <= rx_frames_good + 1'b1;                        // see R6
      end
      if (rx_done) begin
        rx_bytes_total  <= rx_bytes_total + {{(WIDTH-16){1'b0}}, rx_len}; // see R4
        rx_frames_total <= rx_frames_total + 1'b1;                        // see R5
        last_src        <= rx_src;                                        // see R8
      end
      if (ev_crc)
        crc_errors <= crc_errors + 1'b1;
      if (ev_over)
        oversize <= oversize + 1'b1;
      if (ev_frag)
        fragments <= fragments + 1'b1;
      if (ev_jab)
        jabbers <= jabbers + 1'b1;
      if (ev_late)
        late_colls <= late_colls + 1'b1;
      if (ev_mac)
        mac_rx_errors <= mac_rx_errors + 1'b1;
      if (ev_drop)
        dropped <= dropped + 1'b1;
      if (ev_under)
        undersize <= undersize + 1'b1;
      total_errors <= total_errors + {{(WIDTH-4){1'b0}}, err_sum};       // see R17
      // Receive and transmit both feed the histogram; two in one cycle add two
      hist_64        <= hist_64 + {{(WIDTH-1){1'b0}}, rx_bin[0]}
                        + {{(WIDTH-1){1'b0}}, tx_bin[0]};               // see R19
      hist_65_127    <= hist_65_127 + {{(WIDTH-2){1'b0}}, 1'b0, rx_bin[1]}
                        + {{(WIDTH-1){1'b0}}, tx_bin[1]};               // see R19
      hist_128_255   <= hist_128_255 + {{(WIDTH-1){1'b0}}, rx_bin[2]}
                        + {{(WIDTH-1){1'b0}}, tx_bin[2]};
      hist_256_511   <= hist_256_511 + {{(WIDTH-1){1'b0}}, rx_bin[3]}
                        + {{(WIDTH-1){1'b0}}, tx_bin[3]};
      hist_512_1023  <= hist_512_1023 + {{(WIDTH-1){1'b0}}, rx_bin[4]}
                        + {{(WIDTH-1){1'b0}}, tx_bin[4]};
      hist_1024_1536 <= hist_1024_1536 + {{(WIDTH-1){1'b0}}, rx_bin[5]}
                        + {{(WIDTH-1){1'b0}}, tx_bin[5]};
      if (rx_good) begin
        case (rx_cast)
          2'b00: begin
            rx_unicast <= rx_unicast + 1'b1;       // see R20
          end
          2'b01: begin
            rx_multicast <= rx_multicast + 1'b1;   // see R21
          end
          2'b10: begin
            rx_broadcast <= rx_broadcast + 1'b1;   // see R22
          end
          default: begin
          end
        endcase
      end
      if (tx_ok) begin
        case (tx_cast)
          2'b00: begin
            tx_unicast <= tx_unicast + 1'b1;       // see R20
          end
          2'b01: begin
            tx_multicast <= tx_multicast + 1'b1;   // see R21
          end
          2'b10: begin
            tx_broadcast <= tx_broadcast + 1'b1;   // see R22
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Collisions and utilization

  wire [WIDTH-1:0] coll_count;
  event_counter #(
    .WIDTH (WIDTH)
  ) u_coll (
    .clock  (clock),
    .rstn   (rstn),
    .inc    (coll),                 // see R18
    .amount (16'h0001),
    .count  (coll_count)
  );
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      collisions <= {WIDTH{1'b0}};
    else
      collisions <= coll_count;
  end

  // Receive and transmit share one meter; both ending together sums them
  wire [16:0] util_sum = (rx_done ? {1'b0, rx_len} : 17'h0)
                       + (tx_done ? {1'b0, tx_len} : 17'h0);
  wire [7:0]  util_pct;
  // Capacity scales with the interval, so a short interval still reads true
  localparam [63:0] CAP_WIDE = {32'h0, `LINK_BYTES_PER_IV} * INTERVAL_CYC
                             / `UTIL_INTERVAL_CYC;
  util_meter #(
    .INTERVAL_CYC (INTERVAL_CYC),
    .CAP_BYTES    (CAP_WIDE[31:0])
  ) u_util (
    .clock   (clock),
    .rstn    (rstn),
    .add     (rx_done | tx_done),
    .amount  (util_sum[16] ? 16'hFFFF : util_sum[15:0]),
    .percent (util_pct)
  );
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      util_percent <= 8'h00;
    else
      util_percent <= util_pct;   // see R3
  end

endmodule

// ==== tb/port_stats_checker.sv ====
// Port-level assertions for the traffic statistics block.
// Assumes one clock domain and the frame summary ports of the block.
`timescale 1ns/100ps
module port_stats_checker #(
  parameter WIDTH = 32
) (
  input wire             clock,
  input wire             rstn,
  input wire             rx_done,
  input wire [15:0]      rx_len,
  input wire             rx_crc_bad,
  input wire             rx_align_bad,
  input wire             rx_dropped,
  input wire [47:0]      rx_src,
  input wire             tx_done,
  input wire             tx_good,
  input wire             coll,
  input wire [15:0]      coll_octet,
  input wire [WIDTH-1:0] rx_frames_total,
  input wire [WIDTH-1:0] rx_bytes_total,
  input wire [WIDTH-1:0] crc_errors,
  input wire [WIDTH-1:0] oversize,
  input wire [WIDTH-1:0] dropped,
  input wire [47:0]      last_src,
  input wire [WIDTH-1:0] tx_frames_good,
  input wire [WIDTH-1:0] late_colls,
  input wire [WIDTH-1:0] collisions,
  input wire [WIDTH-1:0] total_errors
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////
  frame_total_a:
    assert property (rx_done |=> rx_frames_total == $past(rx_frames_total) + 1)
    else $error("received frame total did not step");
  byte_total_a:
    assert property (rx_done |=> rx_bytes_total == $past(rx_bytes_total) + $past(rx_len))
    else $error("received byte total wrong");
  crc_step_a:
    assert property (rx_done && rx_crc_bad |=> crc_errors == $past(crc_errors) + 1)
    else $error("checksum error count did not step");
  oversize_step_a:
    assert property (rx_done && rx_len > 16'h0600 && !rx_crc_bad && !rx_align_bad
      |=> oversize == $past(oversize) + 1)
    else $error("oversize count did not step");
  drop_step_a:
    assert property (rx_done && rx_dropped |=> dropped == $past(dropped) + 1)
    else $error("dropped count did not step");
  source_kept_a:
    assert property (rx_done |=> last_src == $past(rx_src))
    else $error("last source not taken");
  tx_good_a:
    assert property (tx_done && tx_good |=> tx_frames_good == $past(tx_frames_good) + 1)
    else $error("good transmit count did not step");
  early_coll_a:
    assert property (coll && coll_octet < 16'h0040 |=> $stable(late_colls))
    else $error("early collision counted as late");
  late_coll_a:
    assert property (coll && coll_octet >= 16'h0040 |=> late_colls == $past(late_colls) + 1)
    else $error("late collision not counted");
  coll_step_a:
    assert property (coll |-> ##2 (collisions == $past(collisions) + 1))
    else $error("collision count did not step");
  errors_quiet_a:
    assert property (!rx_done && !coll |=> $stable(total_errors))
    else $error("total errors moved without an event");
  ////////////////////////////////////////////////////////////////
  cover property (rx_done && rx_dropped);
  cover property (coll && coll_octet >= 16'h0040);
  cover property (tx_done && !tx_good);
endmodule
bind port_traffic_statistics port_stats_checker #(.WIDTH(WIDTH)) checker_i (
  .clock, .rstn, .rx_done, .rx_len, .rx_crc_bad, .rx_align_bad, .rx_dropped, .rx_src,
  .tx_done, .tx_good, .coll, .coll_octet, .rx_frames_total, .rx_bytes_total,
  .crc_errors, .oversize, .dropped, .last_src, .tx_frames_good, .late_colls,
  .collisions, .total_errors);

// ==== tb/mac_summary_source.sv ====
// Port MAC model: issues one-cycle end-of-frame and collision summaries.
// Assumes calls from the bench; drives at the falling edge.
`timescale 1ns/100ps
module mac_summary_source (
  // Clock
  input  wire        clock,
  // Receive summary
  output reg         rx_done,
  output reg  [15:0] rx_len,
  output reg         rx_crc_bad,
  output reg         rx_align_bad,
  output reg         rx_mac_err,
  output reg         rx_dropped,
  output reg  [47:0] rx_dst,
  output reg  [47:0] rx_src,
  // Transmit summary
  output reg         tx_done,
  output reg         tx_good,
  output reg  [15:0] tx_len,
  output reg  [47:0] tx_dst,
  // Collisions
  output reg         coll,
  output reg  [15:0] coll_octet
);
  initial begin
    {rx_done, rx_crc_bad, rx_align_bad, rx_mac_err, rx_dropped} = 5'h00;
    {rx_len, rx_dst, rx_src, tx_done, tx_good, tx_len, tx_dst} = '0;
    {coll, coll_octet} = 17'h00000;
  end
  // Flags are crc, align, mac error, dropped; done stays up for back-to-back
  task send_rx(input [15:0] len, input [3:0] flags, input [47:0] dst, input [47:0] src);
    @(negedge clock);
    rx_done = 1'b1;
    rx_len = len;
    {rx_crc_bad, rx_align_bad, rx_mac_err, rx_dropped} = flags;
    rx_dst = dst;
    rx_src = src;
  endtask
  task send_tx(input good, input [15:0] len, input [47:0] dst);
    @(negedge clock);
    tx_done = 1'b1;
    tx_good = good;
    tx_len = len;
    tx_dst = dst;
  endtask
  task send_coll(input [15:0] octet);
    @(negedge clock);
    coll = 1'b1;
    coll_octet = octet;
  endtask
  // Lengths, source and collision octet flip so stale values cannot pass for live ones
  task idle;
    @(negedge clock);
    {rx_done, tx_done, coll} = 3'h0;
    rx_len = ~rx_len;
    rx_src = ~rx_src;
    tx_len = ~tx_len;
    coll_octet = ~coll_octet;
  endtask
endmodule

// ==== tb/port_traffic_statistics_test.sv ====
// Self-checking bench for the traffic statistics block.
// Assumes the MAC summary model and a short utilization interval.
`timescale 1ns/100ps
module port_traffic_statistics_test;
  reg clock = 1'b0;
  reg rstn = 1'b0;
  integer err_count = 0;
  integer n_compared = 0;
  wire rx_done, rx_crc_bad, rx_align_bad, rx_mac_err, rx_dropped, tx_done, tx_good, coll;
  wire [15:0] rx_len, tx_len, coll_octet;
  wire [47:0] rx_dst, rx_src, tx_dst, last_src;
  wire [31:0] tx_bytes_good, rx_bytes_good, rx_bytes_total, rx_frames_total, rx_frames_good;
  wire [31:0] tx_frames_good, crc_errors, oversize, fragments, jabbers, late_colls;
  wire [31:0] mac_rx_errors, dropped, undersize, total_errors, collisions, hist_64;
  wire [31:0] hist_65_127, hist_128_255, hist_256_511, hist_512_1023, hist_1024_1536;
  wire [31:0] rx_unicast, tx_unicast, rx_multicast, tx_multicast, rx_broadcast, tx_broadcast;
  wire [7:0]  util_percent;
  localparam [47:0] UNI = 48'h020000000001, MC = 48'h01005E000001, BC = 48'hFFFFFFFFFFFF;
  always #2 clock = ~clock;
  mac_summary_source src (.clock, .rx_done, .rx_len, .rx_crc_bad, .rx_align_bad,
    .rx_mac_err, .rx_dropped, .rx_dst, .rx_src, .tx_done, .tx_good, .tx_len, .tx_dst,
    .coll, .coll_octet);
  port_traffic_statistics #(.WIDTH(32), .INTERVAL_CYC(100)) dut (.clock, .rstn, .rx_done,
    .rx_len, .rx_crc_bad, .rx_align_bad, .rx_mac_err, .rx_dropped, .rx_dst, .rx_src,
    .tx_done, .tx_good, .tx_len, .tx_dst, .coll, .coll_octet, .tx_bytes_good,
    .rx_bytes_good, .rx_bytes_total, .rx_frames_total, .rx_frames_good, .tx_frames_good,
    .last_src, .crc_errors, .oversize, .fragments, .jabbers, .late_colls, .mac_rx_errors,
    .dropped, .undersize, .total_errors, .collisions, .hist_64, .hist_65_127,
    .hist_128_255, .hist_256_511, .hist_512_1023, .hist_1024_1536, .rx_unicast,
    .tx_unicast, .rx_multicast, .tx_multicast, .rx_broadcast, .tx_broadcast, .util_percent);
  ////////////////////////////////////////////////////////////////
  task check(input string name, input [47:0] seen, input [47:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("CHECK FAILED %0s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task t_zero;
    check("frames total", rx_frames_total, 48'h0);
    check("last source", last_src, 48'h0);
    check("total errors", total_errors, 48'h0);
    check("collisions", collisions, 48'h0);
  endtask
  // Good unicast, dropped multicast at 64 and broadcast at 1536, back to back
  task t_rx_cast;
    src.send_rx(16'h0064, 4'h0, UNI, 48'h00AABB000001);
    src.send_rx(16'h0040, 4'h1, MC, 48'h00AABB000002);
    src.send_rx(16'h0600, 4'h0, BC, 48'h00AABB000003);
    src.idle;
    check("rx good bytes", rx_bytes_good, 48'h06A4);
    check("rx good frames", rx_frames_good, 48'h3);
    check("rx unicast", rx_unicast, 48'h1);
    check("rx multicast", rx_multicast, 48'h1);
    check("rx broadcast", rx_broadcast, 48'h1);
    check("dropped", dropped, 48'h1);
    check("hist 64", hist_64, 48'h1);
    check("hist 1024", hist_1024_1536, 48'h1);
    check("last source", last_src, 48'h00AABB000003);
  endtask
  task t_rx_err;
    src.send_rx(16'h0064, 4'h8, UNI, 48'h1);
    src.send_rx(16'h0601, 4'h0, UNI, 48'h2);
    src.send_rx(16'h0640, 4'h8, UNI, 48'h3);
    src.send_rx(16'h0028, 4'h8, UNI, 48'h4);
    src.send_rx(16'h0028, 4'h0, UNI, 48'h5);
    src.send_rx(16'h0064, 4'h2, UNI, 48'h6);
    src.idle;
    check("crc errors", crc_errors, 48'h3);
    check("oversize", oversize, 48'h1);
    check("fragments", fragments, 48'h1);
    check("jabbers", jabbers, 48'h1);
    check("mac errors", mac_rx_errors, 48'h1);
    check("undersize", undersize, 48'h1);
    check("total errors", total_errors, 48'h9);
    check("rx all bytes", rx_bytes_total, 48'h13FD);
    check("rx all frames", rx_frames_total, 48'h9);
    check("rx good frames", rx_frames_good, 48'h3);
    check("hist 65", hist_65_127, 48'h3);
  endtask
  task t_tx;
    src.send_tx(1'b1, 16'h00C8, UNI);
    src.send_tx(1'b1, 16'h0080, MC);
    src.send_tx(1'b0, 16'h0200, BC);
    src.send_tx(1'b0, 16'h01FF, UNI);
    src.idle;
    check("hist 256", hist_256_511, 48'h1);
    check("tx good bytes", tx_bytes_good, 48'h0148);
    check("tx good frames", tx_frames_good, 48'h2);
    check("tx unicast", tx_unicast, 48'h1);
    check("tx multicast", tx_multicast, 48'h1);
    check("tx broadcast", tx_broadcast, 48'h0);
    check("hist 128", hist_128_255, 48'h2);
    check("hist 512", hist_512_1023, 48'h1);
  endtask
  // Octet 63 is early, octet 64 is the first late one
  task t_coll;
    src.send_coll(16'h003F);
    src.send_coll(16'h0040);
    src.idle;
    repeat (2) @(negedge clock);
    check("collisions", collisions, 48'h2);
    check("late collisions", late_colls, 48'h1);
    check("total errors", total_errors, 48'hA);
  endtask
  // Idle intervals read zero; 25 bytes in a 50-byte interval read half
  task t_util;
    integer k;
    repeat (250) @(negedge clock);
    check("utilization", util_percent, 48'h0);
    src.send_rx(16'h0019, 4'h0, UNI, 48'h7);
    src.idle;
    for (k = 0; k < 120 && util_percent == 8'h00; k = k + 1)
      @(negedge clock);
    check("utilization", util_percent, 48'h32);
  endtask
  task t_rereset;
    @(negedge clock);
    rstn = 1'b0;
    repeat (6) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    t_zero;
  endtask
  initial begin
    repeat (6) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    t_zero;
    t_rx_cast;
    t_rx_err;
    t_tx;
    t_coll;
    t_util;
    t_rereset;
    give_verdict;
  end
  initial begin
    #20000;
    err_count = err_count + 1;
    give_verdict;
  end
endmodule
